// [hdl/conv_pkg.sv]
// Shared constants and types of the six-channel pair conversion control.
package conv_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_PAIRS  = 3;
  localparam int NUM_CH     = 6;
  localparam int CHAN_W     = 3;
  localparam int RES_BITS   = 16;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================================
  // Timing, from the 250 MHz system clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int APERTURE_NS   = 10;
  localparam int CONV_TIME_NS  = 3000;
  // A least time rounds up, a longest time rounds down.
  localparam int APER_CYC = (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W    = 10;

  // ==========================================================================
  // Encodings
  localparam logic RANGE_4X = 1'h0;
  localparam logic RANGE_2X = 1'h1;
  localparam logic SRC_HW   = 1'h0;
  localparam logic SRC_SW   = 1'h1;

  typedef enum logic [1:0] {
    PAIR_IDLE,
    PAIR_APERTURE,
    PAIR_CONVERT
  } pair_state_t;

endpackage

// [hdl/pair_bus_if.sv]
// Signals between the conversion control and one channel-pair sequencer.
`timescale 1ns/1ns
interface pair_bus_if;
  logic start;
  logic rangeSel;
  logic rangeUsed;
  logic hold;
  logic busy;
  logic done;

  modport ctrl (output start, output rangeSel, input rangeUsed, input hold,
                input busy, input done);
  modport unit (input start, input rangeSel, output rangeUsed, output hold,
                output busy, output done);
endinterface

// [hdl/result_fifo.sv]
// Small flip-flop FIFO for conversion result words.
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [PTR_W-1:0] wrPtrQ;
  logic [PTR_W-1:0] rdPtrQ;
  logic [PTR_W:0]   countQ;
  logic             push;
  logic             pop;

  assign inReady  = (countQ != (PTR_W+1)'(DEPTH));
  assign outValid = (countQ != '0);
  assign outData  = memQ[rdPtrQ];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      memQ[wrPtrQ] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (push) begin
        wrPtrQ <= (wrPtrQ == PTR_W'(DEPTH - 1)) ? '0 : wrPtrQ + 1'b1;
      end
      if (pop) begin
        rdPtrQ <= (rdPtrQ == PTR_W'(DEPTH - 1)) ? '0 : rdPtrQ + 1'b1;
      end
      if (push && !pop) begin
        countQ <= countQ + 1'b1;
      end else if (pop && !push) begin
        countQ <= countQ - 1'b1;
      end
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (!resetn)
    countQ == (PTR_W+1)'(DEPTH) && !pop |=> countQ == (PTR_W+1)'(DEPTH) && $stable(wrPtrQ))
    else $error("FIFO accepts data while full.");
endmodule

// [hdl/pair_unit.sv]
// Sequencer of one channel pair: aperture delay, hold and timed conversion.
`timescale 1ns/1ns
module pair_unit
  import conv_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Link to the conversion control
  pair_bus_if.unit  bus
);
  pair_state_t      stateQ;
  logic [CNT_W-1:0] cntQ;
  logic             holdQ;
  logic             busyQ;
  logic             doneQ;
  logic             rangeQ;
  logic [15:0]      holdLenQ;

  assign bus.hold      = holdQ;
  assign bus.busy      = busyQ;
  assign bus.done      = doneQ;
  assign bus.rangeUsed = rangeQ;

  // A start while busy is not looked at; the running conversion goes on.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stateQ <= PAIR_IDLE;
      cntQ   <= '0;
      holdQ  <= 1'h0;
      busyQ  <= 1'h0;
      doneQ  <= 1'h0;
    end else begin
      doneQ <= 1'h0;
      case (stateQ)
        PAIR_IDLE: begin
          if (bus.start) begin
            busyQ  <= 1'h1;
            cntQ   <= CNT_W'(APER_CYC - 1);
            stateQ <= PAIR_APERTURE;
          end
        end
        PAIR_APERTURE: begin
          if (cntQ == '0) begin
            holdQ  <= 1'h1;
            cntQ   <= CNT_W'(CONV_CYC - 1);
            stateQ <= PAIR_CONVERT;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        PAIR_CONVERT: begin
          if (cntQ == '0) begin
            busyQ  <= 1'h0;
            holdQ  <= 1'h0;
            doneQ  <= 1'h1;
            stateQ <= PAIR_IDLE;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        default: begin
          stateQ <= PAIR_IDLE;
        end
      endcase
    end
  end

  // The range is frozen at the start so a change mid-conversion cannot hit it.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rangeQ <= RANGE_4X;
    end else if (bus.start && stateQ == PAIR_IDLE) begin
      rangeQ <= bus.rangeSel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      holdLenQ <= '0;
    end else begin
      holdLenQ <= holdQ ? holdLenQ + 1'b1 : '0;
    end
  end

  a_busy_after_start: assert property (@(posedge clk_sys) disable iff (!resetn)
    bus.start && !busyQ |=> busyQ)
    else $error("Busy did not rise after a start.");
  a_hold_aperture: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(busyQ) |-> !holdQ ##1 !holdQ ##1 !holdQ ##1 holdQ)
    else $error("Hold did not follow the start after the aperture delay.");
  a_conv_length: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(holdQ) |-> holdLenQ == 16'(CONV_CYC))
    else $error("Conversion length differs from the conversion time.");
  a_busy_end_track: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(busyQ) |-> $fell(holdQ) && doneQ)
    else $error("Track did not resume at the end of busy.");
  a_no_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
    holdQ && bus.start && cntQ != '0 |=> holdQ && cntQ == $past(cntQ) - 1'b1)
    else $error("A start disturbed a running conversion.");
  c_one_conversion: cover property (@(posedge clk_sys) disable iff (!resetn)
    $fell(busyQ));
endmodule

// [hdl/conv_control.sv]
// Conversion control of a six-channel converter built from three channel pairs.
`timescale 1ns/1ns

module conv_control
  import conv_pkg::*;
#(
  parameter int RES = RES_BITS
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // Conversion starts from the host
  input  wire logic                  pairOneStart,
  input  wire logic                  pairTwoStart,
  input  wire logic                  pairThreeStart,
  // Mode pins
  input  wire logic                  selectSource,
  input  wire logic                  serialMode,
  input  wire logic                  rangePin,
  // Control register bits
  input  wire logic [NUM_PAIRS-1:0]  pairSelect,
  input  wire logic [NUM_PAIRS-1:0]  rangeSelectBits,
  // Converter core, offset binary per channel
  input  wire logic [NUM_CH*RES-1:0] channelLevel,
  // Status
  output logic                       busy,
  output logic [NUM_PAIRS-1:0]       holdPair,
  // Result read-out
  output logic                       resultValid,
  input  wire logic                  resultReady,
  output logic [RES+CHAN_W:0]        resultData
);
  localparam int WORD_W = RES + CHAN_W + 1;
  localparam int PIN_N  = NUM_PAIRS + 3;

  // ==========================================================================
  // Pin synchronisers
  logic [PIN_N-1:0]     pinMetaQ;
  logic [PIN_N-1:0]     pinSyncQ;
  logic [NUM_PAIRS-1:0] startPrevQ;
  logic [NUM_PAIRS-1:0] startEdge;
  logic [NUM_PAIRS-1:0] startReq;
  logic                 srcSync;
  logic                 serialSync;
  logic                 rangeSync;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pinMetaQ   <= '0;
      pinSyncQ   <= '0;
      startPrevQ <= '0;
    end else begin
      pinMetaQ   <= {rangePin, serialMode, selectSource,
                     pairThreeStart, pairTwoStart, pairOneStart};
      pinSyncQ   <= pinMetaQ;
      startPrevQ <= pinSyncQ[NUM_PAIRS-1:0];
    end
  end

  assign srcSync    = pinSyncQ[NUM_PAIRS];
  assign serialSync = pinSyncQ[NUM_PAIRS+1];
  assign rangeSync  = pinSyncQ[NUM_PAIRS+2];
  // All three edges share one sampling path, so tied starts stay aligned.
  assign startEdge  = pinSyncQ[NUM_PAIRS-1:0] & ~startPrevQ;

  // ==========================================================================
  // Pair selection
  always_comb begin
    if (srcSync == SRC_HW) begin
      startReq = startEdge;
    end else if (serialSync) begin
      startReq = {NUM_PAIRS{startEdge[0]}} & pairSelect;
    end else begin
      startReq = startEdge & pairSelect;
    end
  end

  // ==========================================================================
  // Range for the next conversion
  logic                 busyQ;
  logic                 busyFall;
  logic                 rangeHwQ;
  logic [NUM_PAIRS-1:0] pairBusy;

  // High in the cycle whose edge drops busy, so the pin is taken at that very edge.
  assign busyFall = busyQ && ~|pairBusy;

  // A pin change during a conversion only reaches the conversion after it.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rangeHwQ <= RANGE_4X;
    end else if (busyFall) begin
      rangeHwQ <= rangeSync;
    end
  end

  // ==========================================================================
  // Pair sequencers and sample capture
  logic [NUM_PAIRS-1:0] pairHold;
  logic [NUM_PAIRS-1:0] pairDone;
  logic [NUM_PAIRS-1:0] pairRange;
  logic [NUM_PAIRS-1:0] holdPrevQ;
  logic [RES-1:0]       sampleQ [NUM_CH];
  logic [RES-1:0]       resultQ [NUM_CH];
  logic [NUM_CH-1:0]    rangeTagQ;

  genvar p;
  generate
    for (p = 0; p < NUM_PAIRS; p++) begin : g_pair
      pair_bus_if pbus ();

      assign pbus.start    = startReq[p];
      assign pbus.rangeSel = (srcSync == SRC_HW) ? rangeHwQ : rangeSelectBits[p];
      assign pairBusy[p]   = pbus.busy;
      assign pairHold[p]   = pbus.hold;
      assign pairDone[p]   = pbus.done;
      assign pairRange[p]  = pbus.rangeUsed;

      pair_unit u_pair (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .bus     (pbus.unit)
      );

      // Both channels of a pair are caught at the same edge.
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          holdPrevQ[p]  <= 1'h0;
          sampleQ[2*p]   <= '0;
          sampleQ[2*p+1] <= '0;
        end else begin
          holdPrevQ[p] <= pairHold[p];
          if (pairHold[p] && !holdPrevQ[p]) begin
            sampleQ[2*p]   <= channelLevel[(2*p)*RES +: RES];
            sampleQ[2*p+1] <= channelLevel[(2*p+1)*RES +: RES];
          end
        end
      end

      // Offset binary becomes two's complement by inverting the sign bit.
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          resultQ[2*p]   <= '0;
          resultQ[2*p+1] <= '0;
          rangeTagQ[2*p+1 -: 2] <= '0;
        end else if (pairDone[p]) begin
          resultQ[2*p]   <= {~sampleQ[2*p][RES-1], sampleQ[2*p][RES-2:0]};
          resultQ[2*p+1] <= {~sampleQ[2*p+1][RES-1], sampleQ[2*p+1][RES-2:0]};
          rangeTagQ[2*p+1 -: 2] <= {2{pairRange[p]}};
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Status outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busyQ    <= 1'h0;
      holdPair <= '0;
    end else begin
      busyQ    <= |pairBusy;
      holdPair <= pairHold;
    end
  end

  assign busy = busyQ;

  // ==========================================================================
  // Result queue
  logic [NUM_CH-1:0] pendingQ;
  logic [NUM_CH-1:0] pendingSet;
  logic [NUM_CH-1:0] pendingClr;
  logic [CHAN_W-1:0] nextChan;
  logic              pushValid;
  logic              pushReady;
  logic [WORD_W-1:0] pushData;
  logic              fifoValid;
  logic              fifoPop;
  logic [WORD_W-1:0] fifoData;

  function automatic logic [CHAN_W-1:0] first_set(input logic [NUM_CH-1:0] v);
    logic [CHAN_W-1:0] idx;
    idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CHAN_W'(i);
      end
    end
    return idx;
  endfunction

  assign nextChan  = first_set(pendingQ);
  assign pushValid = |pendingQ;
  assign pushData  = {rangeTagQ[nextChan], nextChan, resultQ[nextChan]};

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pendingSet[i] = pairDone[i/2];
      pendingClr[i] = pushValid && pushReady && (nextChan == CHAN_W'(i));
    end
  end

  // A new result wins over the clear of the same channel in one cycle.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pendingQ <= '0;
    end else begin
      pendingQ <= (pendingQ & ~pendingClr) | pendingSet;
    end
  end

  result_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // The output register keeps a word until the host takes it.
  assign fifoPop = fifoValid && (!resultValid || resultReady);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      resultValid <= 1'h0;
      resultData  <= '0;
    end else if (fifoPop) begin
      resultValid <= 1'h1;
      resultData  <= fifoData;
    end else if (resultReady) begin
      resultValid <= 1'h0;
    end
  end

  // ==========================================================================
  // Checks
  a_start_mapping: assert property (@(posedge clk_sys) disable iff (!resetn)
    srcSync == SRC_HW && startEdge[1] && !pairBusy[1] |=> pairBusy[1])
    else $error("Start two did not start the second pair.");
  a_tied_starts: assert property (@(posedge clk_sys) disable iff (!resetn)
    srcSync == SRC_HW && &startEdge && ~|pairBusy |=> &pairBusy ##4 &pairHold)
    else $error("Tied starts did not hold all pairs together.");
  a_serial_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    srcSync == SRC_SW && serialSync && startEdge[0] |-> startReq == pairSelect)
    else $error("Serial software start did not follow the pair selection.");
  a_range_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    busyFall |=> rangeHwQ == $past(rangeSync))
    else $error("Range pin not taken at the end of busy.");
  a_twos_comp: assert property (@(posedge clk_sys) disable iff (!resetn)
    pairDone[0] |=> resultQ[0][RES-1] == !$past(sampleQ[0][RES-1]))
    else $error("Result sign bit not coded as two's complement.");
  a_result_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
    resultValid && !resultReady |=> resultValid && $stable(resultData))
    else $error("Output register changed before it was read.");
  a_busy_tracks: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(busyQ) |-> $past(pairBusy) == '0)
    else $error("Busy fell while a pair still converted.");
  a_busy_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
    |pairBusy |=> busy)
    else $error("Busy output did not follow a converting pair.");
  a_hold_in_busy: assert property (@(posedge clk_sys) disable iff (!resetn)
    (pairHold & ~pairBusy) == '0)
    else $error("A pair held while it was not busy.");
  // The pairs are instances of one sequencer module, so checks on a single pair stand for all three.
  a_sample_caught: assert property (@(posedge clk_sys) disable iff (!resetn)
    pairHold[0] && !holdPrevQ[0] |=> sampleQ[0] == $past(channelLevel[RES-1:0]))
    else $error("Pair one sample not caught as hold began.");
  a_range_soft: assert property (@(posedge clk_sys) disable iff (!resetn)
    srcSync == SRC_SW && startReq[2] && !pairBusy[2]
    |=> pairRange[2] == $past(rangeSelectBits[2]))
    else $error("Pair three range not taken from its select bit.");
  a_pending_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    pairDone[1] |=> pendingQ[3:2] == 2'h3)
    else $error("Finished pair two results not queued.");

  c_all_pairs: cover property (@(posedge clk_sys) disable iff (!resetn)
    &startReq);
  c_serial_start: cover property (@(posedge clk_sys) disable iff (!resetn)
    srcSync == SRC_SW && serialSync && |startReq);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (!resetn)
    pushValid && !pushReady);
  c_range_two: cover property (@(posedge clk_sys) disable iff (!resetn)
    busyFall ##1 rangeHwQ == RANGE_2X);
endmodule

// [sim/conv_host_model.sv]
// Host model that pulses the pair start pins and drains result words.
`timescale 1ns/1ns
module conv_host_model
  import conv_pkg::*;
(
  // Clock
  input  wire logic                    clk_sys,
  // Start pins
  output logic                         pairOneStart,
  output logic                         pairTwoStart,
  output logic                         pairThreeStart,
  // Result read-out
  input  wire logic                    resultValid,
  output logic                         resultReady,
  input  wire logic [RES_BITS+CHAN_W:0] resultData
);
  // ==========================================================================
  // Start pins
  logic [2:0]                  pins;
  int                          stallLeft;
  logic [RES_BITS+CHAN_W:0]    words[$];

  initial begin
    pins        = 3'h0;
    stallLeft   = 0;
    resultReady = 1'h0;
  end

  assign {pairThreeStart, pairTwoStart, pairOneStart} = pins;

  // A pin is held high for four cycles so the two-stage synchroniser sees it.
  task automatic pulse(input logic [2:0] mask);
    fork
      begin
        @(negedge clk_sys);
        pins = mask;
        repeat (4) @(negedge clk_sys);
        pins = 3'h0;
      end
    join_none
  endtask

  task automatic stall(input int cycles);
    stallLeft = cycles;
  endtask

  // ==========================================================================
  // Result drain
  // Stalling lets the result buffer back up, as a slow host would.
  always @(negedge clk_sys) begin
    if (stallLeft > 0) begin
      stallLeft--;
      resultReady = 1'h0;
    end else begin
      resultReady = 1'h1;
    end
  end

  always @(posedge clk_sys) begin
    if (resultValid === 1'h1 && resultReady === 1'h1) begin
      words.push_back(resultData);
    end
  end
endmodule

// [sim/tb_six_channel_pair_conversion_control.sv]
// Self-checking testbench of the six-channel pair conversion control.
`timescale 1ns/1ns
module tb_six_channel_pair_conversion_control
  import conv_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam logic [NUM_CH*RES_BITS-1:0] LEVELS =
    {16'hABCD, 16'h1234, 16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF};
  logic [NUM_CH*RES_BITS-1:0]  levels;
  logic                         clk_sys;
  logic                         resetn;
  logic                         pairOneStart;
  logic                         pairTwoStart;
  logic                         pairThreeStart;
  logic                         selectSource;
  logic                         serialMode;
  logic                         rangePin;
  logic [NUM_PAIRS-1:0]         pairSelect;
  logic [NUM_PAIRS-1:0]         rangeSelectBits;
  logic                         busy;
  logic [NUM_PAIRS-1:0]         holdPair;
  logic                         resultValid;
  logic                         resultReady;
  logic [RES_BITS+CHAN_W:0]     resultData;
  int                           failCount;
  int                           samplesChecked;

  conv_control #(.RES(RES_BITS)) u_dut (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .pairOneStart    (pairOneStart),
    .pairTwoStart    (pairTwoStart),
    .pairThreeStart  (pairThreeStart),
    .selectSource    (selectSource),
    .serialMode      (serialMode),
    .rangePin        (rangePin),
    .pairSelect      (pairSelect),
    .rangeSelectBits (rangeSelectBits),
    .channelLevel    (levels),
    .busy            (busy),
    .holdPair        (holdPair),
    .resultValid     (resultValid),
    .resultReady     (resultReady),
    .resultData      (resultData)
  );

  conv_host_model u_host (
    .clk_sys        (clk_sys),
    .pairOneStart   (pairOneStart),
    .pairTwoStart   (pairTwoStart),
    .pairThreeStart (pairThreeStart),
    .resultValid    (resultValid),
    .resultReady    (resultReady),
    .resultData     (resultData)
  );

  always #2 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tallyAndFinish();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Follows one conversion of the pairs in mask through busy and hold.
  task automatic waitConv(input logic [2:0] mask);
    int n;
    n = 0;
    while (busy !== 1'h1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n < 50), 32'h1);
    n = 0;
    while (holdPair !== mask && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n), 32'(APER_CYC));
    check(32'(holdPair), 32'(mask));
    n = 0;
    while (holdPair === mask && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n), 32'(CONV_CYC));
    check(32'(busy), 32'h0);
    check(32'(holdPair), 32'h0);
  endtask

  // Compares the words drained by the host with codes reckoned from the inputs.
  task automatic expectWords(input logic [2:0] pairs, input logic [2:0] rng);
    int                       n;
    int                       k;
    logic [RES_BITS-1:0]      lv;
    logic [RES_BITS+CHAN_W:0] e;
    n = 0;
    k = 0;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (pairs[p]) k += 2;
    end
    while (u_host.words.size() < k && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (20) @(negedge clk_sys);
    check(32'(u_host.words.size()), 32'(k));
    for (int c = 0; c < NUM_CH; c++) begin
      if (pairs[c/2] && u_host.words.size() > 0) begin
        lv = levels[c*RES_BITS +: RES_BITS];
        e  = {rng[c/2], CHAN_W'(c), lv ^ {1'h1, {(RES_BITS-1){1'h0}}}};
        check(32'(u_host.words.pop_front()), 32'(e));
      end
    end
    u_host.words.delete();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sPairOne();
    rangePin = 1'h1;
    u_host.pulse(3'h1);
    waitConv(3'h1);
    expectWords(3'h1, 3'h0);
  endtask

  task automatic sAllPairs();
    @(negedge clk_sys);
    rangePin = 1'h0;
    u_host.pulse(3'h7);
    waitConv(3'h7);
    u_host.stall(40);
    expectWords(3'h7, 3'h7);
  endtask

  // Levels change once the pair holds; the words must still carry the held values.
  task automatic sBusyRefuse();
    u_host.pulse(3'h2);
    fork
      begin
        repeat (200) @(negedge clk_sys);
        u_host.pulse(3'h2);
        levels = ~LEVELS;
      end
    join_none
    waitConv(3'h2);
    repeat (30) @(negedge clk_sys);
    check(32'(busy), 32'h0);
    levels = LEVELS;
    expectWords(3'h2, 3'h0);
  endtask

  task automatic sSoftware();
    @(negedge clk_sys);
    selectSource    = SRC_SW;
    serialMode      = 1'h0;
    pairSelect      = 3'h2;
    rangeSelectBits = 3'h2;
    repeat (4) @(negedge clk_sys);
    u_host.pulse(3'h7);
    waitConv(3'h2);
    expectWords(3'h2, 3'h2);
    serialMode      = 1'h1;
    pairSelect      = 3'h5;
    rangeSelectBits = 3'h4;
    repeat (4) @(negedge clk_sys);
    u_host.pulse(3'h1);
    waitConv(3'h5);
    expectWords(3'h5, 3'h4);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    clk_sys         = 1'h0;
    resetn          = 1'h0;
    selectSource    = SRC_HW;
    serialMode      = 1'h0;
    rangePin        = 1'h0;
    pairSelect      = 3'h0;
    rangeSelectBits = 3'h0;
    levels          = LEVELS;
    failCount       = 0;
    samplesChecked  = 0;
    repeat (16) @(negedge clk_sys);
    resetn = 1'h1;
    @(negedge clk_sys);
    check(32'({busy, holdPair, resultValid}), 32'h0);
    sPairOne();
    sAllPairs();
    sBusyRefuse();
    sSoftware();
    tallyAndFinish();
  end

  // Five conversions of about 760 cycles each fit well inside this span.
  initial begin
    repeat (40000) @(posedge clk_sys);
    failCount++;
    tallyAndFinish();
  end
endmodule
